// *** rpsd_pkg.sv ***
// Package of constants and types for the pattern step decoder
package rpsd_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h60;
  localparam logic [7:0] SOFT_RESET_RESET = 8'h00;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int HOLD_HI_LSB = 0;
  localparam int HOLD_LO_LSB = 6;
  localparam int BLUE_LSB = 3;
  localparam int FADE_LSB = 0;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [15:0] HOLD_BASE_US = 16'h0000 + 16'd196_6;
  localparam logic [15:0] HOLD_STEP_US = 16'd196_6;

  // Hold time in ms per code, linear steps
  localparam logic [11:0] HOLD_MS [16] = '{
    12'd197, 12'd393, 12'd590, 12'd786, 12'd983, 12'd1180, 12'd1376, 12'd1573,
    12'd1769, 12'd1966, 12'd2163, 12'd2359, 12'd2556, 12'd2753, 12'd2949, 12'd3146};
  // Fade time in ms per code
  localparam logic [11:0] FADE_MS [8] = '{
    12'd0, 12'd55, 12'd110, 12'd221, 12'd442, 12'd885, 12'd1770, 12'd3539};
  // Blue percent of full_scale_current
  localparam logic [6:0] LIN_PCT [8] = '{
    7'd0, 7'd7, 7'd14, 7'd21, 7'd32, 7'd46, 7'd71, 7'd100};
  localparam logic [6:0] LOG_PCT [8] = '{
    7'd0, 7'd1, 7'd2, 7'd4, 7'd10, 7'd21, 7'd46, 7'd100};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FADE = 2'b01,
    ST_HOLD = 2'b11
  } rpsd_state_t;

  typedef struct packed {
    logic [7:0] cmd_a;
    logic [7:0] cmd_b;
    logic log_mode;
  } rpsd_cmd_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    rpsd_state_t state;
    logic [15:0] tick_cnt;
    logic [11:0] ms_cnt;
    logic [11:0] fade_ms;
    logic [11:0] hold_ms;
    logic [6:0] start_pct;
    logic [6:0] target_pct;
    logic [6:0] blue_pct;
    logic [3:0] hold_code;
    logic [2:0] fade_code;
    logic step_done;
    logic soft_reset;
  } rpsd_state_s_t;

endpackage

// *** rpsd_top.sv ***
// Pattern step decoder: hold time, blue level, fade time, soft reset
// Behaviour
// - Hold code is cmd A bits 1-0 over cmd B bits 7-6, 197 ms to 3146 ms linear.
// - Blue level code in cmd B bits 5-3 maps to linear or logarithmic percent.
// - Fade code in cmd B bits 2-0 selects 0 to 3539 ms.
// - Any write to address 0x60 resets the whole block.
`timescale 1ns/1ps
module rpsd_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register write port
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  // Pattern step
  input wire logic i_step_load,
  input wire rpsd_pkg::rpsd_cmd_t i_cmd,
  // Status
  output logic [6:0] o_blue_pct,
  output logic [3:0] o_hold_code,
  output logic [2:0] o_fade_code,
  output logic [1:0] o_phase,
  output logic o_step_done
);

  rpsd_pkg::rpsd_state_s_t s;
  rpsd_pkg::rpsd_state_s_t next_s;
  logic rst_n;
  logic soft_hit;
  logic tick;
  logic [3:0] code_hold;
  logic [2:0] code_blue;
  logic [2:0] code_fade;
  logic [13:0] ramp;

  assign rst_n = s.rst_sync[1];

  // ***************************************************************
  // Decode
  // ***************************************************************
  assign soft_hit = i_wr && (i_addr == rpsd_pkg::ADDR_SOFT_RESET);
  assign code_hold = {i_cmd.cmd_a[rpsd_pkg::HOLD_HI_LSB +: 2],
                      i_cmd.cmd_b[rpsd_pkg::HOLD_LO_LSB +: 2]};
  assign code_blue = i_cmd.cmd_b[rpsd_pkg::BLUE_LSB +: 3];
  assign code_fade = i_cmd.cmd_b[rpsd_pkg::FADE_LSB +: 3];
  assign tick = (s.tick_cnt == 16'(rpsd_pkg::TICK_CYC - 1));

  // Linear interpolation of fade
  always_comb begin
    ramp = 14'd0;
    if (s.fade_ms != 12'd0) begin
      ramp = 14'((22'(s.target_pct) * 22'(s.ms_cnt)
             + 22'(s.start_pct) * 22'(s.fade_ms - s.ms_cnt)) / 22'(s.fade_ms));
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], 1'b1};
    next_s.step_done = 1'b0;
    next_s.soft_reset = soft_hit;
    next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;
    case (s.state)
      rpsd_pkg::ST_IDLE: begin
        next_s.tick_cnt = 16'h0000;
      end
      rpsd_pkg::ST_FADE: begin
        if (s.ms_cnt >= s.fade_ms) begin
          next_s.state = rpsd_pkg::ST_HOLD;
          next_s.blue_pct = s.target_pct;
          next_s.ms_cnt = 12'h000;
          next_s.tick_cnt = 16'h0000;
        end else begin
          next_s.blue_pct = ramp[6:0];
          if (tick) begin
            next_s.ms_cnt = s.ms_cnt + 12'h001;
          end
        end
      end
      rpsd_pkg::ST_HOLD: begin
        if (tick) begin
          next_s.ms_cnt = s.ms_cnt + 12'h001;
          if (s.ms_cnt + 12'h001 >= s.hold_ms) begin
            next_s.state = rpsd_pkg::ST_IDLE;
            next_s.step_done = 1'b1;
          end
        end
      end
      default: begin
        next_s.state = rpsd_pkg::ST_IDLE;
      end
    endcase
    if (i_step_load) begin
      next_s.state = rpsd_pkg::ST_FADE;
      next_s.hold_code = code_hold;
      next_s.fade_code = code_fade;
      next_s.hold_ms = rpsd_pkg::HOLD_MS[code_hold];
      next_s.fade_ms = rpsd_pkg::FADE_MS[code_fade];
      next_s.start_pct = s.blue_pct;
      // Restart from the level now shown
      next_s.blue_pct = s.blue_pct;
      next_s.target_pct = i_cmd.log_mode ? rpsd_pkg::LOG_PCT[code_blue]
                                         : rpsd_pkg::LIN_PCT[code_blue];
      next_s.ms_cnt = 12'h000;
      next_s.tick_cnt = 16'h0000;
    end
    if (s.soft_reset) begin
      next_s = '0;
      next_s.rst_sync = s.rst_sync;
      // Back-to-back writes clear again
      next_s.soft_reset = soft_hit;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
    end else if (!rst_n) begin
      s <= '0;
      s.rst_sync <= {s.rst_sync[0], 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign o_blue_pct = s.blue_pct;
  assign o_hold_code = s.hold_code;
  assign o_fade_code = s.fade_code;
  assign o_phase = s.state;
  assign o_step_done = s.step_done;

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_soft_reset;
    @(posedge i_clk) disable iff (!rst_n)
    soft_hit && !i_step_load |=> ##1 (s.state == rpsd_pkg::ST_IDLE && s.blue_pct == 7'd0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_hold_code;
    @(posedge i_clk) disable iff (!rst_n)
    i_step_load && !s.soft_reset |=> s.hold_code == $past(code_hold);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("hold code wrong");

  property p_fade_ms;
    @(posedge i_clk) disable iff (!rst_n)
    i_step_load && !s.soft_reset |=> s.fade_ms == rpsd_pkg::FADE_MS[$past(code_fade)];
  endproperty
  a_fade_ms: assert property (p_fade_ms) else $error("fade time wrong");

  property p_blue_target;
    @(posedge i_clk) disable iff (!rst_n)
    s.state == rpsd_pkg::ST_HOLD |-> o_blue_pct == s.target_pct;
  endproperty
  a_blue_target: assert property (p_blue_target) else $error("blue level wrong");

  sequence s_hold_end;
    s.state == rpsd_pkg::ST_HOLD && tick && (s.ms_cnt + 12'h001 >= s.hold_ms);
  endsequence
  property p_advance;
    @(posedge i_clk) disable iff (!rst_n)
    (s_hold_end and (!i_step_load && !s.soft_reset)) |=> o_step_done;
  endproperty
  a_advance: assert property (p_advance) else $error("step did not advance");

  property p_blue_code;
    @(posedge i_clk) disable iff (!rst_n)
    i_step_load && !s.soft_reset |=> s.target_pct == ($past(i_cmd.log_mode)
      ? rpsd_pkg::LOG_PCT[$past(code_blue)] : rpsd_pkg::LIN_PCT[$past(code_blue)]);
  endproperty
  a_blue_code: assert property (p_blue_code) else $error("blue code not decoded");

  property p_hold_ms;
    @(posedge i_clk) disable iff (!rst_n)
    i_step_load && !s.soft_reset |=> s.hold_ms == rpsd_pkg::HOLD_MS[$past(code_hold)];
  endproperty
  a_hold_ms: assert property (p_hold_ms) else $error("hold time wrong");

  property p_phase_load;
    @(posedge i_clk) disable iff (!rst_n)
    i_step_load && !s.soft_reset |=> o_phase == rpsd_pkg::ST_FADE;
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("load did not start fade");

  // Zero fade time: load, then one fade cycle
  sequence s_zero_fade_load;
    i_step_load && !s.soft_reset && code_fade == 3'b000 ##1 !i_step_load && !s.soft_reset;
  endsequence
  property p_zero_fade;
    @(posedge i_clk) disable iff (!rst_n)
    s_zero_fade_load |=> s.state == rpsd_pkg::ST_HOLD && o_blue_pct == s.target_pct;
  endproperty
  a_zero_fade: assert property (p_zero_fade) else $error("zero fade not immediate");

  property p_fade_range;
    @(posedge i_clk) disable iff (!rst_n)
    s.state == rpsd_pkg::ST_FADE |->
      (o_blue_pct >= s.start_pct || o_blue_pct >= s.target_pct)
      && (o_blue_pct <= s.start_pct || o_blue_pct <= s.target_pct);
  endproperty
  a_fade_range: assert property (p_fade_range) else $error("fade level out of range");

  property p_fade_limit;
    @(posedge i_clk) disable iff (!rst_n)
    s.state == rpsd_pkg::ST_FADE |-> s.ms_cnt <= s.fade_ms;
  endproperty
  a_fade_limit: assert property (p_fade_limit) else $error("fade ran too long");

  property p_hold_limit;
    @(posedge i_clk) disable iff (!rst_n)
    s.state == rpsd_pkg::ST_HOLD |-> s.ms_cnt < s.hold_ms;
  endproperty
  a_hold_limit: assert property (p_hold_limit) else $error("hold ran too long");

  property p_done_pulse;
    @(posedge i_clk) disable iff (!rst_n)
    o_step_done |=> !o_step_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("step done too long");

  property p_tick_wrap;
    @(posedge i_clk) disable iff (!rst_n)
    s.tick_cnt < 16'(rpsd_pkg::TICK_CYC);
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("ms timebase overrun");

endmodule

// *** rpsd_host.sv ***
// Host model driving register writes and pattern steps into the decoder
`timescale 1ns/1ps
module rpsd_host (
  // Clock
  input wire logic i_clk,
  // Towards the decoder
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_step_load,
  output rpsd_pkg::rpsd_cmd_t o_cmd
);
  initial begin
    {o_wr, o_addr, o_wdata, o_step_load} = '0;
    o_cmd = '0;
  end

  // One-cycle write; released bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // One-cycle step load
  task automatic ld(input logic [16:0] c);
    @(posedge i_clk);
    o_step_load <= 1'b1;
    o_cmd <= c;
    @(posedge i_clk);
    o_step_load <= 1'b0;
    o_cmd <= ~c;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the pattern step decoder
`timescale 1ns/1ps
module tb_top;
  logic clk, reset_n, wr, step_load, step_done;
  logic [7:0] addr, wdata;
  rpsd_pkg::rpsd_cmd_t cmd;
  logic [6:0] blue_pct;
  logic [3:0] hold_code;
  logic [2:0] fade_code;
  logic [1:0] phase;
  int failures, num_checks;
  // Rows: cmd A, cmd B, log, expected blue, expected phase
  logic [25:0] rows [8] = '{
    {8'h00, 8'h00, 1'h0, 7'h00, 2'h3}, {8'h03, 8'hc8, 1'h0, 7'h07, 2'h3},
    {8'h02, 8'h50, 1'h1, 7'h02, 2'h3}, {8'h01, 8'h98, 1'h0, 7'h15, 2'h3},
    {8'h00, 8'h60, 1'h1, 7'h0a, 2'h3}, {8'h03, 8'h28, 1'h1, 7'h15, 2'h3},
    {8'h02, 8'hb0, 1'h0, 7'h47, 2'h3}, {8'h01, 8'hf8, 1'h1, 7'h64, 2'h3}};

  rpsd_host i_rpsd_host (.i_clk(clk), .o_wr(wr), .o_addr(addr), .o_wdata(wdata),
    .o_step_load(step_load), .o_cmd(cmd));
  rpsd_top i_rpsd_top (.i_clk(clk), .i_reset_n(reset_n), .i_wr(wr), .i_addr(addr),
    .i_wdata(wdata), .i_step_load(step_load), .i_cmd(cmd), .o_blue_pct(blue_pct),
    .o_hold_code(hold_code), .o_fade_code(fade_code), .o_phase(phase),
    .o_step_done(step_done));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial begin
    #(25 * 2000);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    num_checks = 0;
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    chk(16'({phase, step_done, blue_pct}), 16'h0000);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      i_rpsd_host.ld(rows[i][25:9]);
      repeat (3) @(posedge clk);
      #1;
      chk(16'(hold_code), 16'({rows[i][19:18], rows[i][17:16]}));
      chk(16'(fade_code), 16'(rows[i][12:10]));
      chk(16'(blue_pct), 16'(rows[i][8:2]));
      chk(16'(phase), 16'(rows[i][1:0]));
    end
    // Every nonzero fade code starts a fade
    for (int f = 1; f < 8; f++) begin
      i_rpsd_host.ld({8'h00, 5'h00, f[2:0], 1'h0});
      repeat (3) @(posedge clk);
      #1;
      chk(16'(fade_code), 16'(f[2:0]));
      chk(16'(phase), 16'h0001);
      chk(16'(blue_pct), 16'h0064);
      chk(16'(step_done), 16'h0000);
    end
    // Neighbouring address must not reset
    i_rpsd_host.wr(8'h61, 8'hff);
    repeat (2) @(posedge clk);
    #1;
    chk(16'({phase, fade_code}), 16'h000f);
    i_rpsd_host.wr(8'h60, 8'h5a);
    repeat (2) @(posedge clk);
    #1;
    chk({phase, fade_code, hold_code, blue_pct}, 16'h0000);
    // Reset in mid-run, then a load must still be taken
    i_rpsd_host.ld({8'h03, 8'hf8, 1'h0});
    repeat (2) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'({phase, step_done, blue_pct}), 16'h0000);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    i_rpsd_host.ld({8'h02, 8'h98, 1'h1});
    repeat (3) @(posedge clk);
    #1;
    chk(16'(hold_code), 16'h000a);
    chk(16'(blue_pct), 16'h0004);
    tally_and_finish();
  end
endmodule
